// ==== rtl/accr_pkg.sv ====
package accr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// register offsets (word addresses on the register port)
	localparam logic [7:0] CH1_CONFIG_OFS = 8'h0e;
	localparam logic [7:0] CH1_OFFSET_CAL_HIGH_OFS = 8'h0f;
	localparam logic [7:0] CH1_OFFSET_CAL_LOW_OFS = 8'h10;
	localparam logic [7:0] CH1_GAIN_CAL_HIGH_OFS = 8'h11;
	localparam logic [7:0] CH1_GAIN_CAL_LOW_OFS = 8'h12;
	localparam logic [7:0] CH2_CONFIG_OFS = 8'h13;
	localparam logic [7:0] CH2_OFFSET_CAL_HIGH_OFS = 8'h14;

	// reset values
	localparam logic [15:0] CONFIG_RST = 16'h0000;
	localparam logic [15:0] OFFSET_HIGH_RST = 16'h0000;
	localparam logic [15:0] GAIN_HIGH_RST = 16'h8000;
	localparam logic [7:0] CAL_LOW_RST = 8'h00;

	// field positions
	localparam int PHASE_LSB = 6;
	localparam int PHASE_W = 10;
	localparam int BYPASS_BIT = 2;
	localparam int SEL_LSB = 0;
	localparam int CAL_LOW_LSB = 8;

	typedef enum logic [1:0]
	{
		ACCR_SEL_OWN_PAIR = 2'h0,
		ACCR_SEL_SHORTED = 2'h1,
		ACCR_SEL_POS_TEST = 2'h2,
		ACCR_SEL_NEG_TEST = 2'h3
	} accr_sel_t;

	typedef struct packed
	{
		logic signed [9:0] chan_phase_delay;
		logic dc_removal_bypass;
		accr_sel_t input_source_select;
	} accr_cfg_t;

	typedef struct packed
	{
		logic dc_removal_active;
		logic route_own_pair;
		logic route_shorted;
		logic route_pos_test;
		logic route_neg_test;
	} accr_route_t;

endpackage

// ==== rtl/accr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module accr_regs
	import accr_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic global_dc_removal_setting,
	output accr_cfg_t ch1_config,
	output accr_cfg_t ch2_config,
	output accr_route_t ch1_route,
	output accr_route_t ch2_route,
	output logic signed [23:0] ch1_offset_cal,
	output logic [23:0] ch1_gain_cal,
	output logic signed [15:0] ch2_offset_cal_upper
);

	logic [15:0] ch1_config_reg;
	logic [15:0] ch2_config_reg;
	logic [15:0] ch1_offset_high_reg;
	logic [7:0] ch1_offset_low_reg;
	logic [15:0] ch1_gain_high_reg;
	logic [7:0] ch1_gain_low_reg;
	logic [15:0] ch2_offset_high_reg;
	logic [15:0] rdata_next;

	function automatic accr_cfg_t cfg_of(input logic [15:0] w);
		accr_cfg_t c;
		c.chan_phase_delay = w[PHASE_LSB +: PHASE_W];
		c.dc_removal_bypass = w[BYPASS_BIT];
		c.input_source_select = accr_sel_t'(w[SEL_LSB +: 2]);
		return c;
	endfunction

	function automatic accr_route_t route_of(input logic [15:0] w,
		input logic glob);
		accr_route_t r;
		r.dc_removal_active = glob & ~w[BYPASS_BIT];
		r.route_own_pair = (w[SEL_LSB +: 2] == ACCR_SEL_OWN_PAIR);
		r.route_shorted = (w[SEL_LSB +: 2] == ACCR_SEL_SHORTED);
		r.route_pos_test = (w[SEL_LSB +: 2] == ACCR_SEL_POS_TEST);
		r.route_neg_test = (w[SEL_LSB +: 2] == ACCR_SEL_NEG_TEST);
		return r;
	endfunction

	// config words; reserved bits 5:3 never stored
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ch1_config_reg <= CONFIG_RST;
			ch2_config_reg <= CONFIG_RST;
		end
		else if (reg_write)
		begin
			if (reg_addr == CH1_CONFIG_OFS)
				ch1_config_reg <= {reg_wdata[15:6], 3'h0, reg_wdata[2:0]};
			if (reg_addr == CH2_CONFIG_OFS)
				ch2_config_reg <= {reg_wdata[15:6], 3'h0, reg_wdata[2:0]};
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ch1_offset_high_reg <= OFFSET_HIGH_RST;
			ch1_offset_low_reg <= CAL_LOW_RST;
			ch2_offset_high_reg <= OFFSET_HIGH_RST;
		end
		else if (reg_write)
		begin
			if (reg_addr == CH1_OFFSET_CAL_HIGH_OFS)
				ch1_offset_high_reg <= reg_wdata;
			if (reg_addr == CH1_OFFSET_CAL_LOW_OFS)
				ch1_offset_low_reg <= reg_wdata[15:8];
			if (reg_addr == CH2_OFFSET_CAL_HIGH_OFS)
				ch2_offset_high_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ch1_gain_high_reg <= GAIN_HIGH_RST;
			ch1_gain_low_reg <= CAL_LOW_RST;
		end
		else if (reg_write)
		begin
			if (reg_addr == CH1_GAIN_CAL_HIGH_OFS)
				ch1_gain_high_reg <= reg_wdata;
			if (reg_addr == CH1_GAIN_CAL_LOW_OFS)
				ch1_gain_low_reg <= reg_wdata[15:8];
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = 16'h0000;
		case (reg_addr)
			CH1_CONFIG_OFS: rdata_next = ch1_config_reg & 16'hffc7;
			CH1_OFFSET_CAL_HIGH_OFS: rdata_next = ch1_offset_high_reg;
			CH1_OFFSET_CAL_LOW_OFS: rdata_next = {ch1_offset_low_reg, 8'h00};
			CH1_GAIN_CAL_HIGH_OFS: rdata_next = ch1_gain_high_reg;
			CH1_GAIN_CAL_LOW_OFS: rdata_next = {ch1_gain_low_reg, 8'h00};
			CH2_CONFIG_OFS: rdata_next = ch2_config_reg & 16'hffc7;
			CH2_OFFSET_CAL_HIGH_OFS: rdata_next = ch2_offset_high_reg;
			default: rdata_next = 16'h0000;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 16'h0000;
		else if (reg_read)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 16'h0000;
	end

	// datapath view, registered one cycle after the stored words
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ch1_config <= '0;
			ch2_config <= '0;
			ch1_route <= '0;
			ch2_route <= '0;
			ch1_offset_cal <= {OFFSET_HIGH_RST, CAL_LOW_RST};
			ch1_gain_cal <= {GAIN_HIGH_RST, CAL_LOW_RST};
			ch2_offset_cal_upper <= OFFSET_HIGH_RST;
		end
		else
		begin
			ch1_config <= cfg_of(ch1_config_reg);
			ch2_config <= cfg_of(ch2_config_reg);
			ch1_route <= route_of(ch1_config_reg,
				global_dc_removal_setting);
			ch2_route <= route_of(ch2_config_reg,
				global_dc_removal_setting);
			ch1_offset_cal <= {ch1_offset_high_reg, ch1_offset_low_reg};
			ch1_gain_cal <= {ch1_gain_high_reg, ch1_gain_low_reg};
			ch2_offset_cal_upper <= ch2_offset_high_reg;
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence wr_cfg1_s;
		reg_write && reg_addr == CH1_CONFIG_OFS;
	endsequence
	// one-cycle strobe slots, one write and one read per register
	sequence wr_cfg2_s;
		reg_write && reg_addr == CH2_CONFIG_OFS;
	endsequence
	sequence wr_ofs1_hi_s;
		reg_write && reg_addr == CH1_OFFSET_CAL_HIGH_OFS;
	endsequence
	sequence wr_ofs1_lo_s;
		reg_write && reg_addr == CH1_OFFSET_CAL_LOW_OFS;
	endsequence
	sequence wr_gain1_hi_s;
		reg_write && reg_addr == CH1_GAIN_CAL_HIGH_OFS;
	endsequence
	sequence wr_gain1_lo_s;
		reg_write && reg_addr == CH1_GAIN_CAL_LOW_OFS;
	endsequence
	sequence wr_ofs2_hi_s;
		reg_write && reg_addr == CH2_OFFSET_CAL_HIGH_OFS;
	endsequence
	sequence rd_cfg1_s;
		reg_read && reg_addr == CH1_CONFIG_OFS;
	endsequence
	sequence rd_cfg2_s;
		reg_read && reg_addr == CH2_CONFIG_OFS;
	endsequence
	sequence rd_ofs1_hi_s;
		reg_read && reg_addr == CH1_OFFSET_CAL_HIGH_OFS;
	endsequence
	sequence rd_ofs1_lo_s;
		reg_read && reg_addr == CH1_OFFSET_CAL_LOW_OFS;
	endsequence
	sequence rd_gain1_hi_s;
		reg_read && reg_addr == CH1_GAIN_CAL_HIGH_OFS;
	endsequence
	sequence rd_gain1_lo_s;
		reg_read && reg_addr == CH1_GAIN_CAL_LOW_OFS;
	endsequence
	sequence rd_ofs2_hi_s;
		reg_read && reg_addr == CH2_OFFSET_CAL_HIGH_OFS;
	endsequence

	phase_follow_a: assert property (wr_cfg1_s |=> ##1
		ch1_config.chan_phase_delay == $past(reg_wdata[15:6], 2))
		else $error("phase delay not updated");
	resv_zero_a: assert property (##1 $past(reg_read) &&
		($past(reg_addr) == CH1_CONFIG_OFS
		|| $past(reg_addr) == CH2_CONFIG_OFS) |-> reg_rdata[5:3] == 3'h0)
		else $error("config reserved bits nonzero");
	bypass_gate_a: assert property (ch1_route.dc_removal_active
		|-> !$past(ch1_config_reg[2]))
		else $error("dc removal active while bypassed");
	sel_decode_a: assert property (ch1_route.route_shorted
		== ($past(ch1_config_reg[1:0]) == 2'h1))
		else $error("shorted route mismatch");
	low_resv_a: assert property ($past(reg_read) &&
		($past(reg_addr) == CH1_OFFSET_CAL_LOW_OFS
		|| $past(reg_addr) == CH1_GAIN_CAL_LOW_OFS) |-> reg_rdata[7:0] == 8'h00)
		else $error("cal low reserved bits nonzero");
	offset_low_a: assert property (reg_write
		&& reg_addr == CH1_OFFSET_CAL_LOW_OFS
		|=> ##1 ch1_offset_cal[7:0] == $past(reg_wdata[15:8], 2))
		else $error("offset low byte lost");
	gain_high_a: assert property (reg_write
		&& reg_addr == CH1_GAIN_CAL_HIGH_OFS
		|=> ##1 ch1_gain_cal[23:8] == $past(reg_wdata, 2))
		else $error("gain high word lost");
	gain_low_a: assert property (reg_write
		&& reg_addr == CH1_GAIN_CAL_LOW_OFS
		|=> ##1 ch1_gain_cal[7:0] == $past(reg_wdata[15:8], 2))
		else $error("gain low byte lost");
	offset_high_a: assert property (reg_write
		&& reg_addr == CH1_OFFSET_CAL_HIGH_OFS
		|=> ##1 ch1_offset_cal[23:8] == $past(reg_wdata, 2))
		else $error("offset high word lost");
	rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");

	ch2_phase_a: assert property (wr_cfg2_s |=> ##1
		ch2_config.chan_phase_delay == $past(reg_wdata[15:6], 2))
		else $error("channel 2 phase delay not updated");
	cfg1_bypass_a: assert property (wr_cfg1_s |=> ##1
		ch1_config.dc_removal_bypass == $past(reg_wdata[BYPASS_BIT], 2))
		else $error("bypass bit not updated");
	cfg1_sel_a: assert property (wr_cfg1_s |=> ##1
		ch1_config.input_source_select == $past(reg_wdata[1:0], 2))
		else $error("input select not updated");

	bypass_exact_a: assert property ($past(reset_n) |->
		ch1_route.dc_removal_active == ($past(global_dc_removal_setting)
		&& !$past(ch1_config_reg[BYPASS_BIT])))
		else $error("channel 1 dc removal state wrong");
	ch2_bypass_a: assert property ($past(reset_n) |->
		ch2_route.dc_removal_active == ($past(global_dc_removal_setting)
		&& !$past(ch2_config_reg[BYPASS_BIT])))
		else $error("channel 2 dc removal state wrong");
	route_onehot_a: assert property ($past(reset_n) |->
		$onehot({ch1_route.route_own_pair, ch1_route.route_shorted,
		ch1_route.route_pos_test, ch1_route.route_neg_test}))
		else $error("channel 1 route not one-hot");
	route2_onehot_a: assert property ($past(reset_n) |->
		$onehot({ch2_route.route_own_pair, ch2_route.route_shorted,
		ch2_route.route_pos_test, ch2_route.route_neg_test}))
		else $error("channel 2 route not one-hot");
	sel_pos_a: assert property (ch1_route.route_pos_test
		== ($past(ch1_config_reg[1:0]) == 2'h2))
		else $error("positive test route mismatch");
	sel_neg_a: assert property (ch1_route.route_neg_test
		== ($past(ch1_config_reg[1:0]) == 2'h3))
		else $error("negative test route mismatch");
	own_pair1_a: assert property ($past(reset_n) |->
		ch1_route.route_own_pair == ($past(ch1_config_reg[1:0]) == 2'h0))
		else $error("channel 1 own pair route mismatch");
	own_pair2_a: assert property ($past(reset_n) |->
		ch2_route.route_own_pair == ($past(ch2_config_reg[1:0]) == 2'h0))
		else $error("channel 2 own pair route mismatch");

	gain_rst_a: assert property (!$past(reset_n) |->
		ch1_gain_cal == {GAIN_HIGH_RST, CAL_LOW_RST}
		&& ch1_gain_high_reg == GAIN_HIGH_RST)
		else $error("gain not at unity after reset");
	offset_rst_a: assert property (!$past(reset_n) |->
		ch1_offset_cal == {OFFSET_HIGH_RST, CAL_LOW_RST}
		&& ch1_offset_high_reg == OFFSET_HIGH_RST)
		else $error("offset not zero after reset");
	cfg_rst_a: assert property (!$past(reset_n) |->
		ch1_config_reg == CONFIG_RST && ch2_config_reg == CONFIG_RST)
		else $error("config not cleared by reset");
	lows_rst_a: assert property (!$past(reset_n) |->
		ch1_offset_low_reg == CAL_LOW_RST
		&& ch1_gain_low_reg == CAL_LOW_RST)
		else $error("cal low bytes not cleared by reset");

	cfg1_rd_a: assert property (rd_cfg1_s |=>
		reg_rdata == {$past(ch1_config_reg[15:6]), 3'h0,
		$past(ch1_config_reg[2:0])})
		else $error("channel 1 config read wrong");
	cfg2_rd_a: assert property (rd_cfg2_s |=>
		reg_rdata == {$past(ch2_config_reg[15:6]), 3'h0,
		$past(ch2_config_reg[2:0])})
		else $error("channel 2 config read wrong");
	ofs_hi_rd_a: assert property (rd_ofs1_hi_s |=>
		reg_rdata == $past(ch1_offset_high_reg))
		else $error("offset high read wrong");
	ofs_lo_rd_a: assert property (rd_ofs1_lo_s |=>
		reg_rdata[15:8] == $past(ch1_offset_low_reg))
		else $error("offset low read wrong");
	gain_hi_rd_a: assert property (rd_gain1_hi_s |=>
		reg_rdata == $past(ch1_gain_high_reg))
		else $error("gain high read wrong");
	gain_lo_rd_a: assert property (rd_gain1_lo_s |=>
		reg_rdata[15:8] == $past(ch1_gain_low_reg))
		else $error("gain low read wrong");
	ofs2_rd_a: assert property (rd_ofs2_hi_s |=>
		reg_rdata == $past(ch2_offset_high_reg))
		else $error("channel 2 offset high read wrong");

	ofs_hi_wr_a: assert property (wr_ofs1_hi_s |=>
		ch1_offset_high_reg == $past(reg_wdata))
		else $error("offset high write lost");
	ofs_lo_wr_a: assert property (wr_ofs1_lo_s |=>
		ch1_offset_low_reg == $past(reg_wdata[15:8]))
		else $error("offset low write lost");
	gain_hi_wr_a: assert property (wr_gain1_hi_s |=>
		ch1_gain_high_reg == $past(reg_wdata))
		else $error("gain high write lost");
	gain_lo_wr_a: assert property (wr_gain1_lo_s |=>
		ch1_gain_low_reg == $past(reg_wdata[15:8]))
		else $error("gain low write lost");
	ofs2_path_a: assert property (wr_ofs2_hi_s |=> ##1
		ch2_offset_cal_upper == $past(reg_wdata, 2))
		else $error("channel 2 offset high word lost");

	gain_track_a: assert property ($past(reset_n) |->
		ch1_gain_cal == {$past(ch1_gain_high_reg),
		$past(ch1_gain_low_reg)})
		else $error("gain value not assembled from words");
	ofs_track_a: assert property ($past(reset_n) |->
		ch1_offset_cal == {$past(ch1_offset_high_reg),
		$past(ch1_offset_low_reg)})
		else $error("offset value not assembled from words");

endmodule
`default_nettype wire

// ==== tb/accr_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module accr_regs_tb_top
	import accr_pkg::*;
;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
	} accr_row_t;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic global_dc_removal_setting = 1'b1;
	logic [DATA_W-1:0] reg_rdata;
	accr_cfg_t ch1_config;
	accr_cfg_t ch2_config;
	accr_route_t ch1_route;
	accr_route_t ch2_route;
	logic signed [23:0] ch1_offset_cal;
	logic [23:0] ch1_gain_cal;
	logic signed [15:0] ch2_offset_cal_upper;
	int miscompares = 0;
	int cmp_count = 0;
	accr_row_t rows [8] = '{
		'{8'h0e, 16'hffff, 16'hffc7},
		'{8'h0f, 16'h8001, 16'h8001},
		'{8'h10, 16'habcd, 16'hab00},
		'{8'h11, 16'h1234, 16'h1234},
		'{8'h12, 16'hffff, 16'hff00},
		'{8'h13, 16'h5a5a, 16'h5a42},
		'{8'h14, 16'h7fff, 16'h7fff},
		'{8'h20, 16'hffff, 16'h0000}
	};
	always #5 clk = ~clk;
	accr_regs accr_regs_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.global_dc_removal_setting(global_dc_removal_setting),
		.ch1_config(ch1_config), .ch2_config(ch2_config), .ch1_route(ch1_route),
		.ch2_route(ch2_route), .ch1_offset_cal(ch1_offset_cal),
		.ch1_gain_cal(ch1_gain_cal),
		.ch2_offset_cal_upper(ch2_offset_cal_upper));
	task automatic chk(input string name, input logic [23:0] exp,
		input logic [23:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		summarize();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h11, 16'h8000);
		rd(8'h0f, 16'h0000);
		chk("gain_after_rst", 24'h800000, ch1_gain_cal);
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].rdata);
		end
		settle();
		chk("ch1_offset_cal", 24'h8001ab, ch1_offset_cal);
		chk("ch1_gain_cal", 24'h1234ff, ch1_gain_cal);
		chk("ch2_offset_upper", 24'h007fff, {8'h00, ch2_offset_cal_upper});
		chk("ch1_config", 24'h001fff, {11'h000, ch1_config});
		chk("ch2_config", 24'h000b4a, {11'h000, ch2_config});
		// every select code, bypass both ways, global both ways
		for (int k = 0; k < 16; k++)
		begin
			@(posedge clk);
			global_dc_removal_setting <= k[3];
			wr(8'h0e, {4'h8, 6'h00, 3'b000, k[2], k[1:0]});
			wr(8'h13, {6'h00, 4'h3, 3'b000, ~k[2], k[1:0]});
			settle();
			chk("ch1_route", {19'h0, k[3] & ~k[2], 4'h8 >> k[1:0]},
				{19'h0, ch1_route});
			chk("ch2_route", {19'h0, k[3] & k[2], 4'h8 >> k[1:0]},
				{19'h0, ch2_route});
			chk("ch1_phase", 24'hfffe00, {{14{ch1_config.chan_phase_delay[9]}},
				ch1_config.chan_phase_delay});
			chk("ch2_phase", 24'h000003,
				{14'h0000, ch2_config.chan_phase_delay});
		end
		// second reset in mid-run
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("gain_in_reset", 24'h800000, ch1_gain_cal);
		@(posedge clk);
		reset_n <= 1'b1;
		rd(8'h0e, 16'h0000);
		rd(8'h0f, 16'h0000);
		rd(8'h10, 16'h0000);
		rd(8'h11, 16'h8000);
		rd(8'h12, 16'h0000);
		rd(8'h13, 16'h0000);
		rd(8'h14, 16'h0000);
		settle();
		chk("ch1_offset_rst", 24'h000000, ch1_offset_cal);
		chk("ch1_gain_rst", 24'h800000, ch1_gain_cal);
		summarize();
	end
endmodule
`default_nettype wire
